// [hdl/clock_source_startup_sequencer.sv]
`timescale 1ns/1ps
module clock_source_startup_sequencer (
    input wire logic aclk, // System clock, 200 MHz
    input wire logic aresetn, // Synchronous reset, low active
    input clk_startup_pkg::fuse_t fuse_in, // Raw fuse image
    input wire logic other_reset_active, // Any other reset source holding
    input wire logic wdt_osc_tick, // Watchdog oscillator cycle pulse
    input wire logic [5:0] osc_tick, // Per-source oscillator cycle pulses
    input wire logic wake_event, // Wake from power-save or power-down
    output logic sys_clk_en, // Gated, divided core clock enable
    output logic core_reset_n, // Core reset, low active
    input wire logic [3:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [3:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);
    import clk_startup_pkg::*;

    typedef enum logic [2:0] {
        ST_FUSE, ST_HOLD, ST_TOUT, ST_STAB, ST_RUN, ST_SLEEP, ST_INVALID
    } seq_state_t;

    // Source from the stored code; fuse levels used as stored
    function automatic logic [2:0] decode_source(input logic [3:0] code);
        if (code[3]) begin
            decode_source = SRC_LP_XTAL;
        end else begin
            case (code[2:0])
                3'h7, 3'h6: decode_source = SRC_FS_XTAL;
                3'h5, 3'h4: decode_source = SRC_LF_XTAL;
                3'h3: decode_source = SRC_RC_128K;
                3'h2: decode_source = SRC_RC_CAL;
                3'h0: decode_source = SRC_EXT_CLK;
                default: decode_source = SRC_RESERVED;
            endcase
        end
    endfunction

    // Time-out in watchdog cycles from start-up and source fuses
    function automatic logic [13:0] timeout_len(input fuse_t f);
        logic [2:0] sel;
        sel = {f.clock_source_select_fuses[0], f.startup_time_fuses};
        timeout_len = TOUT_LONG;
        case (decode_source(f.clock_source_select_fuses))
            SRC_LP_XTAL, SRC_FS_XTAL: begin
                case (sel)
                    3'h0, 3'h3, 3'h6: timeout_len = TOUT_SHORT;
                    3'h2, 3'h5: timeout_len = TOUT_NONE;
                    default: timeout_len = TOUT_LONG;
                endcase
            end
            default: begin
                case (f.startup_time_fuses)
                    2'h0: timeout_len = TOUT_NONE;
                    2'h1: timeout_len = TOUT_SHORT;
                    default: timeout_len = TOUT_LONG;
                endcase
            end
        endcase
    endfunction

    // Stability count in selected oscillator cycles
    function automatic logic [15:0] stable_len(input fuse_t f);
        logic [2:0] sel;
        sel = {f.clock_source_select_fuses[0], f.startup_time_fuses};
        stable_len = CK_RC;
        case (decode_source(f.clock_source_select_fuses))
            SRC_LP_XTAL, SRC_FS_XTAL: begin
                case (sel)
                    3'h0, 3'h1: stable_len = CK_258;
                    3'h2, 3'h3, 3'h4: stable_len = CK_1K;
                    default: stable_len = CK_16K;
                endcase
            end
            SRC_LF_XTAL: stable_len = sel[2] ? CK_32K : CK_1K;
            SRC_EXT_CLK: stable_len = CK_EXT;
            default: stable_len = CK_RC;
        endcase
    endfunction

    // Captured fuses and derived settings
    fuse_t fuse_q, fuse_d; // Fuse image, frozen after capture
    logic [2:0] src_q, src_d; // Selected source
    logic [13:0] tout_q, tout_d; // Time-out target
    logic [15:0] stab_q, stab_d; // Stability target without reset extra
    logic [2:0] range_q, range_d; // Low-power frequency range code
    logic div8_on; // Programmed divider fuse

    // Sequencer state
    seq_state_t state_q, state_d; // Start-up state
    logic [15:0] cnt_q, cnt_d; // Tick counter for both phases
    logic from_reset_q, from_reset_d; // Count includes reset extra
    logic [2:0] div_q, div_d; // Divide-by-eight phase
    logic clk_en_q, clk_en_d; // Core clock enable
    logic rstn_q, rstn_d; // Core reset level
    logic sel_tick; // Tick of the chosen source
    logic [15:0] stab_target; // Full stability target this run
    logic sleep_req; // Software sleep request pulse

    assign div8_on = !fuse_q.divide_by_eight_fuse;
    assign sel_tick = (src_q < SRC_RESERVED) ? osc_tick[src_q] : 1'b0;
    assign stab_target = from_reset_q ? stab_q + CK_RESET_EXTRA : stab_q;

    // Fuse capture: once, on the first cycle after reset release
    always_comb begin
        fuse_d = fuse_q;
        src_d = src_q;
        tout_d = tout_q;
        stab_d = stab_q;
        range_d = range_q;
        if (state_q == ST_FUSE) begin
            fuse_d = fuse_in;
            src_d = decode_source(fuse_in.clock_source_select_fuses);
            tout_d = timeout_len(fuse_in);
            stab_d = stable_len(fuse_in);
            range_d = fuse_in.clock_source_select_fuses[3:1];
        end
    end

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        from_reset_d = from_reset_q;
        div_d = div_q;
        clk_en_d = 1'b0;
        rstn_d = rstn_q;
        case (state_q)
            ST_FUSE: begin
                state_d = ST_HOLD;
                rstn_d = 1'b0;
            end
            ST_HOLD: begin
                // Wait for every other reset source to let go
                cnt_d = 16'h0000;
                from_reset_d = 1'b1;
                rstn_d = 1'b0;
                if (!other_reset_active) begin
                    if (src_q == SRC_RESERVED) begin
                        state_d = ST_INVALID;
                    end else if (tout_q == TOUT_NONE) begin
                        state_d = ST_STAB;
                    end else begin
                        state_d = ST_TOUT;
                    end
                end
            end
            ST_TOUT: begin
                if (wdt_osc_tick) begin
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_q == {2'b00, tout_q} - 16'h0001) begin
                        state_d = ST_STAB;
                        cnt_d = 16'h0000;
                    end
                end
            end
            ST_STAB: begin
                if (sel_tick) begin
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_q == stab_target - 16'h0001) begin
                        state_d = ST_RUN;
                        rstn_d = 1'b1;
                        div_d = 3'h0;
                    end
                end
            end
            ST_RUN: begin
                // Only here does the core see clock cycles
                rstn_d = 1'b1;
                if (sel_tick) begin
                    div_d = div_q + 3'h1;
                    clk_en_d = !div8_on || (div_q == DIV8_LAST);
                end
                if (sleep_req) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // Oscillator assumed stopped; supply assumed good on wake
                cnt_d = 16'h0000;
                if (wake_event) begin
                    state_d = ST_STAB;
                    from_reset_d = 1'b0;
                end
            end
            ST_INVALID: rstn_d = 1'b0;
            default: state_d = ST_HOLD;
        endcase
        // Any other reset source restarts the whole sequence
        if (other_reset_active && state_q != ST_FUSE) begin
            state_d = ST_HOLD;
            rstn_d = 1'b0;
            clk_en_d = 1'b0;
        end
    end

    // Sequencer registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fuse_q <= FUSE_DEFAULT;
            src_q <= SRC_RC_CAL;
            tout_q <= TOUT_LONG;
            stab_q <= CK_RC;
            range_q <= 3'h0;
            state_q <= ST_FUSE;
            cnt_q <= 16'h0000;
            from_reset_q <= 1'b1;
            div_q <= 3'h0;
            clk_en_q <= 1'b0;
            rstn_q <= 1'b0;
        end else begin
            fuse_q <= fuse_d;
            src_q <= src_d;
            tout_q <= tout_d;
            stab_q <= stab_d;
            range_q <= range_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            from_reset_q <= from_reset_d;
            div_q <= div_d;
            clk_en_q <= clk_en_d;
            rstn_q <= rstn_d;
        end
    end

    assign sys_clk_en = clk_en_q;
    assign core_reset_n = rstn_q;

    // AXI4-Lite slave; one write and one read at a time
    logic aw_have_q, aw_have_d; // Write address held
    logic w_have_q, w_have_d; // Write data held
    logic [3:0] awaddr_q, awaddr_d; // Held write address
    logic [31:0] wdata_q, wdata_d; // Held write data
    logic [3:0] wstrb_q, wstrb_d; // Held strobes
    logic bvalid_q, bvalid_d; // Write response pending
    logic [1:0] bresp_q, bresp_d; // Write response code
    logic rvalid_q, rvalid_d; // Read data pending
    logic [1:0] rresp_q, rresp_d; // Read response code
    logic [31:0] rdata_q, rdata_d; // Read data
    logic sleep_q, sleep_d; // Sleep request pulse
    logic [31:0] status_word; // Live status view

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_STATE_POS +: 3] = state_q;
        status_word[ST_RSTN_POS] = rstn_q;
        status_word[ST_CLKEN_POS] = (state_q == ST_RUN);
        status_word[ST_SRC_POS +: 3] = src_q;
        status_word[ST_FUSE_POS +: 7] = fuse_q;
        status_word[ST_RANGE_POS +: 3] = range_q;
    end

    assign sleep_req = sleep_q;

    // Bus next state
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        sleep_d = 1'b0;
        if (s_axi_awvalid && !aw_have_q) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_q) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // Both halves in hand: act on the write
        if (aw_have_q && w_have_q && !bvalid_q) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            case ({awaddr_q[3:2], 2'b00})
                OFS_CTRL: sleep_d = wstrb_q[0] && wdata_q[CTRL_SLEEP_BIT];
                OFS_STATUS, OFS_COUNT: bresp_d = RESP_OKAY;
                default: bresp_d = RESP_SLVERR;
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            case ({s_axi_araddr[3:2], 2'b00})
                OFS_CTRL: rdata_d = 32'h0000_0000;
                OFS_STATUS: rdata_d = status_word;
                OFS_COUNT: rdata_d = {16'h0000, cnt_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            sleep_q <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            sleep_q <= sleep_d;
        end
    end

    // Ready is high whenever the holding slot is empty
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_other_reset_hold: assert property (other_reset_active && state_q != ST_FUSE
        |=> !rstn_q && state_q == ST_HOLD) else $error("reset not held");
    a_tout_length: assert property (state_q == ST_TOUT && state_d == ST_STAB
        |-> wdt_osc_tick && cnt_q == {2'b00, tout_q} - 16'h0001) else $error("time-out length");
    a_stab_release: assert property (state_q == ST_STAB && state_d == ST_RUN
        |-> sel_tick && cnt_q == stab_target - 16'h0001) else $error("stability length");
    a_clk_gated: assert property (clk_en_q |-> $past(state_q) == ST_RUN)
        else $error("clock before release");
    a_div_eight: assert property (clk_en_q && div8_on |-> $past(div_q) == DIV8_LAST)
        else $error("divider phase");
    a_wake_no_tout: assert property (state_q == ST_SLEEP && wake_event && !other_reset_active
        |=> state_q == ST_STAB && !from_reset_q && rstn_q) else $error("wake path");
    a_reserved_held: assert property (src_q == SRC_RESERVED && state_q != ST_FUSE
        |-> !rstn_q && state_q != ST_RUN) else $error("reserved released");
    a_fuse_frozen: assert property (state_q != ST_FUSE |=> $stable(fuse_q))
        else $error("fuse changed");
    a_bresp_hold: assert property (bvalid_q && !s_axi_bready |=> bvalid_q && $stable(bresp_q))
        else $error("write response dropped");

    c_reach_run: cover property (state_q == ST_STAB ##1 state_q == ST_RUN);
    c_sleep_wake: cover property (state_q == ST_SLEEP ##1 state_q == ST_STAB);
    c_divided_tick: cover property (clk_en_q && div8_on);
    c_reserved: cover property (state_q == ST_INVALID);

endmodule // clock_source_startup_sequencer

// [hdl/clk_startup_pkg.sv]
// Notes on behaviour
// - Decode four-bit source code, route chosen clock
// - Fuse bit one means unprogrammed, zero programmed
// - Factory default: code 0010, start-up 10, divide on
// - Extra time-out after other resets release
// - Time-out counted on watchdog oscillator ticks
// - Time-out lengths: 0, 512 or 8192 cycles
// - Count selected oscillator ticks, then release reset
// - Stability count depends on clock type
// - Reset: time-out plus stability; wake: stability only
// - Low-power upper bits give frequency range
// - Low-power start-up table, low select bit zero
// - Low-power start-up table, low select bit one
// - Divide-by-eight fuse programmed divides clock by 8
package clk_startup_pkg;

    // Fuse image as stored, one means unprogrammed
    typedef struct packed {
        logic [3:0] clock_source_select_fuses; // Source code
        logic [1:0] startup_time_fuses;        // Start-up code
        logic divide_by_eight_fuse;            // Zero divides by 8
    } fuse_t;

    localparam fuse_t FUSE_DEFAULT = '{4'h2, 2'h2, 1'b0};

    // Source selector values, also index into the tick vector
    localparam logic [2:0] SRC_LP_XTAL = 3'h0;
    localparam logic [2:0] SRC_FS_XTAL = 3'h1;
    localparam logic [2:0] SRC_LF_XTAL = 3'h2;
    localparam logic [2:0] SRC_RC_128K = 3'h3;
    localparam logic [2:0] SRC_RC_CAL = 3'h4;
    localparam logic [2:0] SRC_EXT_CLK = 3'h5;
    localparam logic [2:0] SRC_RESERVED = 3'h6;
    localparam int NUM_SRC = 6;

    // Watchdog oscillator time-out lengths
    localparam logic [13:0] TOUT_NONE = 14'h0000;
    localparam logic [13:0] TOUT_SHORT = 14'h0200;
    localparam logic [13:0] TOUT_LONG = 14'h2000;

    // Stability counts in cycles of the chosen oscillator
    localparam logic [15:0] CK_EXT = 16'h0006;
    localparam logic [15:0] CK_RC = 16'h0006;
    localparam logic [15:0] CK_258 = 16'h0102;
    localparam logic [15:0] CK_1K = 16'h0400;
    localparam logic [15:0] CK_16K = 16'h4000;
    localparam logic [15:0] CK_32K = 16'h8000;
    localparam logic [15:0] CK_RESET_EXTRA = 16'h000E;

    // Divider terminal count for divide-by-eight
    localparam logic [2:0] DIV8_LAST = 3'h7;

    // Register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_COUNT = 4'h8;
    localparam int CTRL_SLEEP_BIT = 0;

    // Status field positions
    localparam int ST_STATE_POS = 0;
    localparam int ST_RSTN_POS = 4;
    localparam int ST_CLKEN_POS = 5;
    localparam int ST_SRC_POS = 8;
    localparam int ST_FUSE_POS = 16;
    localparam int ST_RANGE_POS = 24;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [sim/osc_source_model.sv]
`timescale 1ns/1ps
// Stand-in for the oscillators and the other reset sources
module osc_source_model (
    input wire logic aclk, // Bench clock
    input wire logic wdt_en, // Let watchdog oscillator run
    input wire logic osc_en, // Let selected oscillator run
    input wire logic slow, // Tick only every other cycle
    input wire logic [2:0] src, // Which oscillator is running
    input wire logic hold_rst, // Other reset source holding
    output logic wdt_osc_tick, // Watchdog cycle pulse
    output logic [5:0] osc_tick, // Per-source cycle pulses
    output logic other_reset_active // Other reset level
);
    logic phase_q = 1'b0; // Slow-rate phase
    logic live; // Tick allowed this cycle

    // Phase flips every cycle, so slow mode halves the rate
    always_ff @(posedge aclk) begin
        phase_q <= ~phase_q;
    end

    assign live = ~slow | phase_q;
    // Only the chosen source oscillates; idle sources stay quiet
    assign wdt_osc_tick = wdt_en & live;
    assign osc_tick = (osc_en & live) ? (6'h01 << src) : 6'h00;
    // Bench picks time-outs covering its own supply ramp
    assign other_reset_active = hold_rst;
endmodule // osc_source_model

// [sim/clock_source_startup_sequencer_bench.sv]
`timescale 1ns/1ps
module clock_source_startup_sequencer_bench;
    import clk_startup_pkg::*;
    typedef struct {logic [6:0] f; logic [2:0] s; int t; int k; int d;} case_t;
    // Fuse image, source, time-out, stability, divide
    case_t cases [6] = '{
        '{7'h14, SRC_RC_CAL, 8192, 20, 8},
        '{7'h51, SRC_LP_XTAL, 512, 272, 1},
        '{7'h5B, SRC_LP_XTAL, 0, 16398, 1},
        '{7'h01, SRC_EXT_CLK, 0, 20, 1},
        '{7'h1A, SRC_RC_128K, 512, 20, 8},
        '{7'h23, SRC_LF_XTAL, 512, 1038, 1}};
    logic aclk = 0, aresetn = 0, wake = 0, wdt_en = 0, osc_en = 0, slow = 0, hold = 0;
    logic [2:0] src = 3'h0;
    logic [6:0] fuse = 7'h14;
    logic wdt_osc_tick, other_reset_active, sys_clk_en, core_reset_n;
    logic [5:0] osc_tick;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000, rdata, d;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int failures = 0, num_checks = 0, pulses = 0, p0;

    // 200 MHz clock
    always #2.5 aclk = ~aclk;
    // Core clock pulses, counted off the sampling edge to avoid races
    always @(negedge aclk) if (sys_clk_en === 1'b1) pulses++;

    clock_source_startup_sequencer i_dut (.aclk(aclk), .aresetn(aresetn), .fuse_in(fuse),
        .other_reset_active(other_reset_active), .wdt_osc_tick(wdt_osc_tick),
        .osc_tick(osc_tick), .wake_event(wake), .sys_clk_en(sys_clk_en),
        .core_reset_n(core_reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    osc_source_model i_src (.aclk(aclk), .wdt_en(wdt_en), .osc_en(osc_en), .slow(slow),
        .src(src), .hold_rst(hold), .wdt_osc_tick(wdt_osc_tick), .osc_tick(osc_tick),
        .other_reset_active(other_reset_active));

    // Single comparison for every kind of value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Let exactly n oscillator cycles through
    task automatic ticks(input bit wd, input int n);
        int c = 0;
        @(posedge aclk);
        if (wd) wdt_en <= 1'b1;
        else osc_en <= 1'b1;
        while (c < n) begin
            @(posedge aclk);
            if (wd ? wdt_osc_tick : |osc_tick) c++;
        end
        wdt_en <= 1'b0;
        osc_en <= 1'b0;
    endtask

    // Bus write; address and data offered together
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        if (n == 100) chk(0, 1, "write hang");
        chk(bresp, er, "bresp");
    endtask

    // Bus read
    task automatic rd(input logic [3:0] a, output logic [31:0] v, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        v = rdata;
        rready <= 1'b0;
        if (n == 100) chk(0, 1, "read hang");
        chk(rresp, er, "rresp");
    endtask

    // Reset with one fuse setting and walk the whole start-up
    task automatic run_case(input int i);
        @(posedge aclk);
        aresetn <= 1'b0; fuse <= cases[i].f; hold <= 1'b1; slow <= i[0]; src <= cases[i].s;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        fuse <= 7'h08; // Reserved code now; must be ignored
        p0 = pulses;
        ticks(1, 600); // Watchdog runs while other reset holds
        hold <= 1'b0;
        if (cases[i].t > 0) begin
            ticks(1, cases[i].t - 1);
            ticks(0, 40);
            chk(core_reset_n, 0, "timeout short");
            ticks(1, 1);
        end
        ticks(0, cases[i].k - 1);
        repeat (3) @(posedge aclk);
        chk(core_reset_n, 0, "stability short");
        chk(pulses - p0, 0, "clock leaked");
        ticks(0, 1);
        @(posedge aclk);
        #1 chk(core_reset_n, 1, "release");
        p0 = pulses;
        ticks(0, 16);
        repeat (3) @(posedge aclk);
        chk(pulses - p0, 16 / cases[i].d, "divide");
        rd(OFS_STATUS, d, RESP_OKAY);
        chk(d[10:8], cases[i].s, "source");
        chk(d[26:16], {cases[i].f[6:4], 1'b0, cases[i].f}, "fuse image");
        $display("case %0d done", i);
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Cut a hang well beyond the expected run, about 80k cycles
    initial begin
        #400_000;
        failures++;
        finish_test();
    end

    initial begin
        for (int i = 0; i < 6; i++) run_case(i);
        // Sleep, then wake with stability count only
        wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
        p0 = pulses;
        ticks(0, 16);
        chk(pulses - p0, 0, "sleep clock");
        @(posedge aclk);
        wake <= 1'b1;
        @(posedge aclk);
        wake <= 1'b0;
        // Last case is the low-frequency crystal: 1K ticks, no reset extra
        ticks(0, 1023);
        repeat (2) @(posedge aclk);
        rd(OFS_STATUS, d, RESP_OKAY);
        chk(d[5:0], 6'h13, "wake still counting");
        rd(OFS_COUNT, d, RESP_OKAY);
        chk(d, 32'd1023, "wake count");
        ticks(0, 1);
        repeat (2) @(posedge aclk);
        rd(OFS_STATUS, d, RESP_OKAY);
        chk(d[5:0], 6'h34, "wake run");
        // Unmapped offset
        wr(4'hC, 32'h0000_0001, RESP_SLVERR);
        rd(4'hC, d, RESP_SLVERR);
        chk(d, 32'h0000_0000, "unmapped data");
        $display("sleep and bus test done");
        // Reserved source code never releases
        @(posedge aclk);
        aresetn <= 1'b0; fuse <= 7'h09;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        ticks(1, 8192);
        ticks(0, 200);
        chk(core_reset_n, 0, "reserved held");
        rd(OFS_STATUS, d, RESP_OKAY);
        chk(d[2:0], 3'h6, "reserved state");
        $display("reserved test done");
        finish_test();
    end
endmodule // clock_source_startup_sequencer_bench
